//--- hw/cbcms_bridge.sv
// module: core-to-bus access bridge with mode-dependent resync wait states
`timescale 1ns/1ns
`default_nettype none
// Function
// [R1] sync mode: core clock integer multiple, not slower
// [R2] async mode: core clock not slower than bus
// [R3] sync mode: domains phase aligned, edges reusable
// [R4] sync mode: at least one wait state; the code inserts none when clockRatioOne is set
// [R5] async mode: at least two wait states
// [R6] async mode: resynchronise on every access
// [R7] sync mode: delay only when frequencies differ
// [R8] shared clock: no wait states inserted
// [R9] peripheral clocks come from bus clock
// [R10] mode chosen by clock mode select value
// [R11] waits are whole bus clocks via ready
// [R12] async requests pass two-flop synchroniser
module cbcms_bridge (
	input  wire logic                 clk,
	input  wire logic                 resetn,
	input  wire logic [1:0]           clockModeSelect,
	input  wire logic                 clockRatioOne,
	input  wire logic                 coreReqValid,
	input  wire cbcms_pkg::cbcms_req_t coreReq,
	output logic                      coreRspValid,
	output cbcms_pkg::cbcms_rsp_t      coreRsp,
	output logic                      busValid,
	output cbcms_pkg::cbcms_req_t      busReq,
	input  wire logic                 busReady,
	input  wire logic [31:0]          busRdata,
	input  wire logic                 busError,
	output logic                      periphClkEn,
	output logic                      coreWait
);
	import cbcms_pkg::*;

	// ******************************
	// state
	// ******************************
	typedef enum logic [1:0] {IDLE, SYNCING, WAITING, BUSY} cbcms_state_t;

	cbcms_state_t      state_reg;
	cbcms_state_t      state_next;
	cbcms_mode_t       mode_reg;
	cbcms_mode_t       mode_next;
	cbcms_req_t        req_reg;
	cbcms_req_t        req_next;
	cbcms_rsp_t        rsp_reg;
	cbcms_rsp_t        rsp_next;
	logic [WAIT_W-1:0] wait_reg;
	logic [WAIT_W-1:0] wait_next;
	logic              rspV_reg;
	logic              rspV_next;
	logic              syncStage_reg  [SYNC_STAGES];
	logic              syncStage_next [SYNC_STAGES];
	logic              syncLaunch;
	logic              syncDone;
	logic              busDone;
	logic [WAIT_W-1:0] waitMin;

	// ******************************
	// access qualifiers
	// ******************************
	// the chain is only fed while an access waits for it
	assign syncLaunch = (state_reg == SYNCING); // [R6]
	assign syncDone   = syncStage_reg[SYNC_STAGES-1]; // [R12]
	assign busDone    = (state_reg == BUSY) && busReady; // [R11]

	// ******************************
	// wait count per mode
	// ******************************
	always_comb begin
		case (mode_reg)
			CBCMS_MODE_SYNC: begin
				// equal frequencies keep edges aligned: no wait
				if (clockRatioOne) begin // [R7] [R3]
					waitMin = WAIT_ZERO;
				end else begin
					waitMin = SYNC_WAIT_MIN; // [R4]
				end
			end
			CBCMS_MODE_ASYNC: begin
				waitMin = ASYNC_WAIT_MIN; // [R5]
			end
			CBCMS_MODE_FAST: begin
				waitMin = FAST_WAIT_MIN; // [R8]
			end
			default: begin
				waitMin = FAST_WAIT_MIN;
			end
		endcase
	end

	// ******************************
	// mode select
	// ******************************
	always_comb begin
		mode_next = mode_reg;
		// mode only changes between accesses
		if (state_reg == IDLE) begin
			// code 3 is ignored and keeps the mode in force
			if (clockModeSelect <= CBCMS_MODE_FAST) begin
				mode_next = cbcms_mode_t'(clockModeSelect); // [R10]
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			mode_reg <= cbcms_mode_t'(CLOCK_MODE_RESET);
		end else begin
			mode_reg <= mode_next;
		end
	end

	// ******************************
	// access sequencing
	// ******************************
	always_comb begin
		state_next = state_reg;
		req_next   = req_reg;
		wait_next  = wait_reg;
		case (state_reg)
			IDLE: begin
				if (coreReqValid) begin
					req_next  = coreReq;
					wait_next = waitMin;
					if (mode_reg == CBCMS_MODE_ASYNC) begin
						state_next = SYNCING; // [R5]
					end else if (waitMin == WAIT_ZERO) begin
						state_next = BUSY; // [R8]
					end else begin
						state_next = WAITING; // [R4]
					end
				end
			end
			SYNCING: begin
				// fresh resync for each access
				if (syncDone) begin // [R6]
					wait_next  = WAIT_ZERO;
					state_next = BUSY;
				end
			end
			WAITING: begin
				wait_next = wait_reg - 3'h1; // [R11]
				if (wait_reg == 3'h1) begin
					state_next = BUSY;
				end
			end
			BUSY: begin
				// request stands until the bus answers ready
				if (busDone) begin // [R11]
					state_next = IDLE;
				end
			end
			default: begin
				state_next = IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_reg <= IDLE;
			req_reg   <= '0;
			wait_reg  <= WAIT_ZERO;
		end else begin
			state_reg <= state_next;
			req_reg   <= req_next;
			wait_reg  <= wait_next;
		end
	end

	// ******************************
	// response
	// ******************************
	always_comb begin
		rsp_next  = rsp_reg;
		rspV_next = 1'h0;
		if (busDone) begin
			// answer taken on the ready edge, held until the next one
			rsp_next.rdata = busRdata;
			rsp_next.error = busError;
			rspV_next      = 1'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			rsp_reg  <= '0;
			rspV_reg <= 1'h0;
		end else begin
			rsp_reg  <= rsp_next;
			rspV_reg <= rspV_next;
		end
	end

	// ******************************
	// resync chain
	// ******************************
	genvar stage;
	generate
		for (stage = 0; stage < SYNC_STAGES; stage++) begin : g_sync
			if (stage == 0) begin : g_first
				always_comb begin
					syncStage_next[stage] = syncLaunch;
				end
			end else begin : g_rest
				// later stages only see the one before
				always_comb begin
					syncStage_next[stage] = syncStage_reg[stage-1];
				end
			end

			always_ff @(posedge clk) begin
				if (!resetn) begin
					syncStage_reg[stage] <= 1'h0;
				end else begin
					syncStage_reg[stage] <= syncStage_next[stage];
				end
			end
		end
	endgenerate

	// ******************************
	// outputs
	// ******************************
	assign busValid     = (state_reg == BUSY);
	assign busReq       = req_reg;
	assign coreRsp      = rsp_reg;
	assign coreRspValid = rspV_reg;
	assign coreWait     = (state_reg != IDLE);
	assign periphClkEn  = 1'h1; // [R9]

endmodule : cbcms_bridge
`default_nettype wire

//--- hw/cbcms_pkg.sv
// package: mode encodings, wait counts and carrier types for the clock bridge
package cbcms_pkg;

	typedef enum logic [1:0] {
		CBCMS_MODE_SYNC  = 2'h0,
		CBCMS_MODE_ASYNC = 2'h1,
		CBCMS_MODE_FAST  = 2'h2
	} cbcms_mode_t;

	localparam logic [1:0] CLOCK_MODE_RESET = 2'h2;
	localparam int         ADDR_W           = 32;
	localparam int         DATA_W           = 32;
	localparam int         WAIT_W           = 3;
	localparam logic [2:0] SYNC_WAIT_MIN    = 3'h1;
	localparam logic [2:0] ASYNC_WAIT_MIN   = 3'h2;
	localparam logic [2:0] FAST_WAIT_MIN    = 3'h0;
	localparam logic [2:0] WAIT_ZERO        = 3'h0;
	localparam logic [1:0] SYNC_STAGES      = 2'h2;

	typedef struct packed {
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} cbcms_req_t;

	typedef struct packed {
		logic [DATA_W-1:0] rdata;
		logic              error;
	} cbcms_rsp_t;

endpackage : cbcms_pkg

//--- testbench/cbcms_bridge_asserts.sv
// checker: access timing of the bridge
`timescale 1ns/1ns
`default_nettype none
module cbcms_bridge_asserts (
	input wire logic clk, resetn, clockRatioOne, coreReqValid, busValid,
	input wire logic busReady, coreRspValid, coreWait, periphClkEn,
	input wire logic [1:0] clockModeSelect,
	input wire cbcms_pkg::cbcms_req_t coreReq, busReq
);
	wire logic t = coreReqValid && !coreWait;
	wire logic [1:0] m = clockModeSelect;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	fast_wait_a: assert property (t && m == 2'h2 |=> busValid)
		else $error("wait");
	sync_wait_a: assert property (t && !m && !clockRatioOne |=>
		!busValid ##1 busValid) else $error("wait");
	sync_equal_a: assert property (t && !m && clockRatioOne |=> busValid)
		else $error("wait");
	async_wait_a: assert property (t && m == 2'h1 |=>
		!busValid [*3] ##1 busValid) else $error("wait");
	rsp_after_a: assert property (busValid && busReady |=>
		coreRspValid && !coreWait) else $error("rsp");
	req_hold_a: assert property (busValid && !busReady |=>
		busValid && $stable(busReq)) else $error("hold");
	req_copy_a: assert property (t && m == 2'h2 |=>
		busReq == $past(coreReq)) else $error("copy");
	periph_clk_a: assert property (periphClkEn) else $error("pclk");
	cover property (t && m == 2'h1);
	cover property (t && !m && !clockRatioOne);
	cover property (busValid && !busReady);
endmodule : cbcms_bridge_asserts
`default_nettype wire

//--- testbench/cbcms_bus_model.sv
// model: bus fabric slave with a set stall
`timescale 1ns/1ns
`default_nettype none
module cbcms_bus_model (
	input wire logic clk, busValid,
	input wire logic [2:0] stall,
	input wire cbcms_pkg::cbcms_req_t busReq,
	output logic busReady, busError,
	output logic [31:0] busRdata
);
	logic [2:0] cntReg = 3'h0;
	always_ff @(posedge clk)
		cntReg <= (busValid && !busReady) ? cntReg + 3'h1 : 3'h0;
	assign busReady = busValid && cntReg == stall;
	// data inverted only in the answer cycle
	assign busRdata = busReady ? ~busReq.addr : busReq.addr;
	assign busError = busReady ? busReq.addr[0] : !busReq.addr[0];
endmodule : cbcms_bus_model
`default_nettype wire

//--- testbench/cbcms_bridge_tb.sv
// bench: per-mode latency, data path and reset
`timescale 1ns/1ns
`default_nettype none
module cbcms_bridge_tb;
	logic clk = 0, resetn = 0, clockRatioOne = 0, coreReqValid = 0;
	logic busValid, busReady, busError, coreRspValid, periphClkEn, coreWait;
	logic [1:0] clockModeSelect = 2'h0;
	logic [2:0] stall = 3'h0;
	logic [31:0] busRdata;
	cbcms_pkg::cbcms_req_t coreReq = '0, busReq;
	cbcms_pkg::cbcms_rsp_t coreRsp;
	int miscompares = 0, tests_run = 0, n;
	// rows: mode, ratio one, stall, cycles to response
	logic [10:0] rows [6] = '{11'h401, 11'h002, 11'h101,
		11'h464, 11'h204, 11'h246};
	cbcms_bridge cbcms_bridge_inst (.*);
	cbcms_bus_model cbcms_bus_model_inst (.*);
	initial forever #10 clk = ~clk;
	task automatic check(input logic [31:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("FAIL %0t got %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic finish_test;
		$display("runs %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : finish_test
	task automatic access(input logic [10:0] r, input logic [31:0] a);
		@(posedge clk) {clockModeSelect, clockRatioOne, stall} <= r[10:5];
		@(posedge clk) coreReq <= '{1'b0, a, ~a};
		coreReqValid <= 1'b1;
		@(posedge clk) coreReqValid <= 1'b0;
		n = 0;
		while (coreRspValid !== 1'b1 && n < 20) begin
			@(posedge clk) #1 n++;
		end
		check(32'(n), 32'(r[4:0]));
		check(coreRsp.rdata, ~a);
		check(32'(coreRsp.error), 32'(a[0]));
	endtask : access
	initial begin
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		foreach (rows[i]) access(rows[i], 32'hC0DE0000 + 32'(i));
		// async access cut by reset just before it reaches the bus
		@(posedge clk) coreReqValid <= 1'b1;
		@(posedge clk) coreReqValid <= 1'b0;
		@(posedge clk) #1 check(32'(coreWait), 32'h1);
		@(posedge clk) {resetn, clockModeSelect} <= 3'h3;
		@(posedge clk) #1
			check(32'({busValid, coreWait, coreRspValid}), 32'h0);
		@(posedge clk) resetn <= 1'b1;
		// code 3 keeps the reset mode: shared clock
		access(11'h601, 32'h1);
		finish_test;
	end
	initial begin
		#20000 miscompares++;
		finish_test;
	end
endmodule : cbcms_bridge_tb
bind cbcms_bridge cbcms_bridge_asserts cbcms_bridge_asserts_inst (.*);
`default_nettype wire
